/* smc_consts.svh */
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// command address field
`define SMC_CMD_W 6
`define SMC_CMD_SCAN_VOLT 6'h01
`define SMC_CMD_SCAN_TEMP 6'h02
`define SMC_CMD_SCAN_MIXED 6'h03
`define SMC_CMD_SCAN_WIRES 6'h04
`define SMC_CMD_SCAN_ALL 6'h05
`define SMC_CMD_SCAN_CONT 6'h06
`define SMC_CMD_MEASURE 6'h08
`define SMC_CMD_READ_ALL 6'h3f
`define SMC_SUFFIX_NONE 6'h00

// stack position field
`define SMC_POS_W 4
`define SMC_POS_BOTTOM 4'h1
`define SMC_POS_ALL 4'hf

// command frame lengths in command clocks
`define SMC_FRAME_CHAIN 5'h18
`define SMC_FRAME_ALONE 5'h10
`define SMC_CNT_W 5

// bit positions in the shifted frame (lsb = last bit in)
`define SMC_CH_DEV_LSB 20
`define SMC_CH_CMD_LSB 14
`define SMC_CH_SUF_LSB 8
`define SMC_CH_RD_BIT 7
`define SMC_SA_CMD_LSB 10
`define SMC_SA_SUF_LSB 4
`define SMC_SA_RD_BIT 3

// voltage scan cell order
`define SMC_CELL_W 4
`define SMC_CELL_PACK 4'h0
`define SMC_CELL_LOW 4'h1

// power mode codes, gray along standby-active-standby
`define SMC_MODE_STANDBY 2'b00
`define SMC_MODE_ACTIVE 2'b01
`define SMC_MODE_SLEEP 2'b11
`define SMC_MODE_SHUTDOWN 2'b10

// scan kind codes
`define SMC_KIND_NONE 3'h0
`define SMC_KIND_VOLT 3'h1
`define SMC_KIND_TEMP 3'h2
`define SMC_KIND_MIXED 3'h3
`define SMC_KIND_WIRES 3'h4
`define SMC_KIND_ALL 3'h5
`define SMC_KIND_CONT 3'h6
`define SMC_KIND_MEAS 3'h7

`endif

/* smc_pkg.sv */
`include "smc_consts.svh"

package smc_pkg;

  typedef enum logic [1:0] {
    SMC_STANDBY = `SMC_MODE_STANDBY,
    SMC_ACTIVE = `SMC_MODE_ACTIVE,
    SMC_SLEEP = `SMC_MODE_SLEEP,
    SMC_SHUTDOWN = `SMC_MODE_SHUTDOWN
  } smc_mode_t;

  typedef enum logic [2:0] {
    SMC_K_NONE = `SMC_KIND_NONE,
    SMC_K_VOLT = `SMC_KIND_VOLT,
    SMC_K_TEMP = `SMC_KIND_TEMP,
    SMC_K_MIXED = `SMC_KIND_MIXED,
    SMC_K_WIRES = `SMC_KIND_WIRES,
    SMC_K_ALL = `SMC_KIND_ALL,
    SMC_K_CONT = `SMC_KIND_CONT,
    SMC_K_MEAS = `SMC_KIND_MEAS
  } smc_kind_t;

endpackage

/* smc_top.sv */
// Function
// - chain holds at most 14 devices, 12 cells
// - bottom is position 1, top is n
// - bottom talks spi, one chain port up
// - middle uses up and down ports
// - top uses only its down port
// - chain replies carry position, parameter, address tags
// - read-all address streams measurement data
// - addressed, top, bottom devices drive timing
// - results stored raw, filters only for faults
// - normal, sleep, shutdown; sleep on command/watchdog
// - sleep keeps the continuous flag but runs no timed scans; traffic wakes device
// - enable low shuts down, no factory reload
// - normal mode splits into standby and active
// - single scan, continuous scan, single measure
// - busy device ignores scan, still forwards it
// - addresses 1-5 scan once, 6 continuous
// - address 8 measures element chosen by suffix
// - command address fields are six bits
// - converter results are fourteen bits wide
// - start synced to clock 24 or 16
// - addressed devices start scans right away
// - voltage scan runs cell 12 down, then pack
// - finished scan returns device to standby
`include "smc_consts.svh"

module smc_top #(
  parameter int P_MAX_DEVICES = 14,
  parameter int P_CELLS = 12,
  parameter int P_ADC_BITS = 14
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_link_clock,
  input wire logic i_link_frame,
  input wire logic i_link_data,
  input wire logic [`SMC_POS_W-1:0] i_stack_pos,
  input wire logic [`SMC_POS_W-1:0] i_stack_size,
  input wire logic i_enable,
  input wire logic i_sleep_cmd,
  input wire logic i_wdog_timeout,
  input wire logic i_comm_activity,
  input wire logic i_scan_inhibit,
  input wire logic i_scan_tick,
  input wire logic i_sample_done,
  input wire logic i_scan_done,
  input wire logic i_adc_valid,
  input wire logic [P_ADC_BITS-1:0] i_adc_data,
  output smc_pkg::smc_mode_t o_mode,
  output smc_pkg::smc_kind_t o_scan_kind,
  output logic o_scan_start,
  output logic o_scan_cont,
  output logic [`SMC_CMD_W-1:0] o_meas_elem,
  output logic [`SMC_CELL_W-1:0] o_cell_sel,
  output logic o_stream_start,
  output logic o_fwd_cmd,
  output logic o_timing_master,
  output logic o_spi_en,
  output logic o_port_up_en,
  output logic o_port_down_en,
  output logic o_tag_reply,
  output logic o_config_err,
  output logic o_fast_osc_en,
  output logic o_bias_en,
  output logic o_factory_load,
  output logic o_result_filter_en,
  output logic o_fault_filter_en,
  output logic o_result_valid,
  output logic [P_ADC_BITS-1:0] o_result_data
);
  import smc_pkg::*;

  // ---------------- link domain ----------------
  logic link_rst_n;
  logic [1:0] alone_link_sync;
  logic [`SMC_FRAME_CHAIN-1:0] shift, word;
  logic [`SMC_CNT_W-1:0] bit_cnt, frame_len;
  logic word_alone, word_tgl, frame_full, pend_clr_seen;
  logic core_alone; // driven in the core domain from the stack size pins

  // counter ends with the frame itself, link clock may stop afterwards
  assign link_rst_n = i_rst_n & i_link_frame;

  // command frame length chosen by chain or standalone system
  assign frame_len = alone_link_sync[1] ? `SMC_FRAME_ALONE : `SMC_FRAME_CHAIN;
  assign frame_full = (bit_cnt == frame_len);

  // standalone strap brought into the link domain
  always_ff @(posedge i_link_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      alone_link_sync <= 2'b00;
    else
      alone_link_sync <= {alone_link_sync[0], core_alone};
  end

  // command bits shifted in on rising command clock
  always_ff @(posedge i_link_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      shift <= '0;
      bit_cnt <= '0;
    end
    else if (!frame_full)
    begin
      shift <= {shift[`SMC_FRAME_CHAIN-2:0], i_link_data};
      bit_cnt <= bit_cnt + `SMC_CNT_W'(1);
    end
  end

  // capture on the falling edge of the last command clock
  always_ff @(negedge i_link_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      word <= '0;
      word_alone <= 1'b0;
      word_tgl <= 1'b0;
      pend_clr_seen <= 1'b0;
    end
    else if (i_link_frame && frame_full && !pend_clr_seen)
    begin
      word <= shift;
      word_alone <= alone_link_sync[1];
      word_tgl <= ~word_tgl;
      pend_clr_seen <= 1'b1;
    end
    else if (!frame_full)
      pend_clr_seen <= 1'b0;
  end

  // ---------------- core domain ----------------
  logic [2:0] tgl_sync, cmd_kind;
  logic [1:0] en_sync;
  logic [`SMC_POS_W-1:0] pos_s1, pos, size_s1, size;
  logic cmd_evt, cmd_read;
  logic [`SMC_POS_W-1:0] cmd_dev;
  logic [`SMC_CMD_W-1:0] cmd_addr, cmd_suf;
  logic is_bottom, is_top, is_middle, addressed;
  logic busy, start_ok, cmd_known;
  logic last_addressed, por_seen, cell_run;
  smc_mode_t mode, next_mode;

  // crossing: toggle through two flops, third flop only for the edge
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tgl_sync <= 3'b000;
    else
      tgl_sync <= {tgl_sync[1:0], word_tgl};
  end
  assign cmd_evt = tgl_sync[2] ^ tgl_sync[1];

  // pin inputs synchronised before use
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      en_sync <= 2'b00;
      pos_s1 <= '0;
      pos <= '0;
      size_s1 <= '0;
      size <= '0;
    end
    else
    begin
      en_sync <= {en_sync[0], i_enable};
      pos_s1 <= i_stack_pos;
      pos <= pos_s1;
      size_s1 <= i_stack_size;
      size <= size_s1;
    end
  end

  // stack role from position and count
  assign core_alone = (size <= `SMC_POS_BOTTOM);
  assign is_bottom = (pos == `SMC_POS_BOTTOM) && !core_alone;
  assign is_top = (pos == size) && !core_alone;
  assign is_middle = !core_alone && !is_bottom && !is_top;

  // frame fields; word stays still long after its toggle
  assign cmd_dev = word_alone ? `SMC_POS_ALL : word[`SMC_CH_DEV_LSB +: `SMC_POS_W];
  assign cmd_addr = word_alone ? word[`SMC_SA_CMD_LSB +: `SMC_CMD_W]
                               : word[`SMC_CH_CMD_LSB +: `SMC_CMD_W];
  assign cmd_suf = word_alone ? word[`SMC_SA_SUF_LSB +: `SMC_CMD_W]
                              : word[`SMC_CH_SUF_LSB +: `SMC_CMD_W];
  assign cmd_read = word_alone ? !word[`SMC_SA_RD_BIT] : !word[`SMC_CH_RD_BIT];
  assign addressed = (cmd_dev == `SMC_POS_ALL) || (cmd_dev == pos);

  // measurement command decode
  function automatic logic [2:0] kind_of(input logic [`SMC_CMD_W-1:0] a,
                                         input logic [`SMC_CMD_W-1:0] s);
    kind_of = `SMC_KIND_NONE;
    case (a)
      `SMC_CMD_SCAN_VOLT: kind_of = (s == `SMC_SUFFIX_NONE) ? `SMC_KIND_VOLT : `SMC_KIND_NONE;
      `SMC_CMD_SCAN_TEMP: kind_of = (s == `SMC_SUFFIX_NONE) ? `SMC_KIND_TEMP : `SMC_KIND_NONE;
      `SMC_CMD_SCAN_MIXED: kind_of = (s == `SMC_SUFFIX_NONE) ? `SMC_KIND_MIXED : `SMC_KIND_NONE;
      `SMC_CMD_SCAN_WIRES: kind_of = (s == `SMC_SUFFIX_NONE) ? `SMC_KIND_WIRES : `SMC_KIND_NONE;
      `SMC_CMD_SCAN_ALL: kind_of = (s == `SMC_SUFFIX_NONE) ? `SMC_KIND_ALL : `SMC_KIND_NONE;
      `SMC_CMD_SCAN_CONT: kind_of = (s == `SMC_SUFFIX_NONE) ? `SMC_KIND_CONT : `SMC_KIND_NONE;
      `SMC_CMD_MEASURE: kind_of = `SMC_KIND_MEAS;
      default: kind_of = `SMC_KIND_NONE;
    endcase
  endfunction

  assign cmd_kind = kind_of(cmd_addr, cmd_suf);
  assign cmd_known = (cmd_kind != `SMC_KIND_NONE);
  assign busy = (mode == SMC_ACTIVE) || o_scan_cont;
  assign start_ok = cmd_evt && cmd_read && addressed && cmd_known && !busy
                    && (mode == SMC_STANDBY);

  // power mode machine
  always_comb
  begin
    next_mode = mode;
    case (mode)
      SMC_STANDBY:
        if (!en_sync[1])
          next_mode = SMC_SHUTDOWN;
        else if (i_sleep_cmd || i_wdog_timeout)
          next_mode = SMC_SLEEP;
        else if (start_ok && cmd_kind != `SMC_KIND_CONT)
          next_mode = SMC_ACTIVE;
        else if (o_scan_cont && i_scan_tick)
          next_mode = SMC_ACTIVE;
      SMC_ACTIVE:
        if (!en_sync[1])
          next_mode = SMC_SHUTDOWN;
        else if (i_scan_done)
          next_mode = SMC_STANDBY;
      SMC_SLEEP:
        if (!en_sync[1])
          next_mode = SMC_SHUTDOWN;
        else if (cmd_evt || i_comm_activity)
          next_mode = SMC_STANDBY;
      SMC_SHUTDOWN:
        if (en_sync[1])
          next_mode = SMC_STANDBY;
      default:
        next_mode = SMC_STANDBY;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      mode <= SMC_SHUTDOWN;
    else
      mode <= next_mode;
  end

  // scan start, kind, element and continuous flag
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_scan_start <= 1'b0;
      o_scan_kind <= SMC_K_NONE;
      o_scan_cont <= 1'b0;
      o_meas_elem <= '0;
    end
    else
    begin
      o_scan_start <= (start_ok && cmd_kind == `SMC_KIND_CONT)
                      || (mode == SMC_STANDBY && next_mode == SMC_ACTIVE);
      if (start_ok)
      begin
        o_scan_kind <= smc_kind_t'(cmd_kind);
        o_meas_elem <= cmd_suf;
      end
      if (start_ok && cmd_kind == `SMC_KIND_CONT)
        o_scan_cont <= 1'b1;
      else if (i_scan_inhibit || mode == SMC_SHUTDOWN)
        o_scan_cont <= 1'b0;
    end
  end

  // voltage scan: cell 12 down to cell 1, then pack
  assign cell_run = o_scan_kind == SMC_K_VOLT || o_scan_kind == SMC_K_MIXED
                    || o_scan_kind == SMC_K_ALL || o_scan_kind == SMC_K_CONT;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cell_sel <= `SMC_CELL_PACK;
    else if (o_scan_start)
      o_cell_sel <= `SMC_CELL_W'(P_CELLS);
    else if (mode == SMC_ACTIVE && cell_run && i_sample_done
             && o_cell_sel != `SMC_CELL_PACK)
      o_cell_sel <= o_cell_sel - `SMC_CELL_W'(1);
  end

  // forwarding, streaming and timing roles
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fwd_cmd <= 1'b0;
      o_stream_start <= 1'b0;
      last_addressed <= 1'b0;
    end
    else
    begin
      o_fwd_cmd <= cmd_evt && !is_top && !core_alone;
      o_stream_start <= cmd_evt && cmd_read && addressed
                        && cmd_addr == `SMC_CMD_READ_ALL;
      if (cmd_evt)
        last_addressed <= addressed && (cmd_dev != `SMC_POS_ALL);
    end
  end

  // port enables and role outputs
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_timing_master <= 1'b0;
      o_spi_en <= 1'b0;
      o_port_up_en <= 1'b0;
      o_port_down_en <= 1'b0;
      o_tag_reply <= 1'b0;
      o_config_err <= 1'b0;
    end
    else
    begin
      o_timing_master <= is_bottom || is_top || last_addressed || core_alone;
      o_spi_en <= is_bottom || core_alone;
      o_port_up_en <= is_bottom || is_middle;
      o_port_down_en <= is_middle || is_top;
      o_tag_reply <= !core_alone;
      o_config_err <= (size > `SMC_POS_W'(P_MAX_DEVICES)) || (pos > size)
                      || (pos == '0);
    end
  end

  // power domains, factory load and result path
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mode <= SMC_SHUTDOWN;
      o_fast_osc_en <= 1'b0;
      o_bias_en <= 1'b0;
      o_factory_load <= 1'b0;
      por_seen <= 1'b0;
      o_result_filter_en <= 1'b0;
      o_fault_filter_en <= 1'b0;
      o_result_valid <= 1'b0;
      o_result_data <= '0;
    end
    else
    begin
      o_mode <= next_mode;
      o_fast_osc_en <= next_mode == SMC_STANDBY || next_mode == SMC_ACTIVE;
      o_bias_en <= next_mode != SMC_SHUTDOWN;
      o_factory_load <= !por_seen;
      por_seen <= 1'b1;
      o_result_filter_en <= 1'b0;
      o_fault_filter_en <= 1'b1;
      o_result_valid <= i_adc_valid;
      if (i_adc_valid)
        o_result_data <= i_adc_data;
    end
  end

endmodule

/* smc_link_host.sv */
module smc_link_host (
  output logic o_link_clock,
  output logic o_link_frame,
  output logic o_link_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: clock still and low, no frame
  initial
  begin
    o_link_clock = 1'b0;
    o_link_frame = 1'b0;
    o_link_data = 1'b1;
  end

  // one read frame, msb first, data moves after each falling edge
  task automatic send(input logic [23:0] w, input int n);
    #13;
    o_link_frame = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_link_data = w[i];
      #40 o_link_clock = 1'b1;
      #40 o_link_clock = 1'b0;
    end
    #20 o_link_frame = 1'b0;
    o_link_data = ~o_link_data; // released line shows no stale bit
    #40;
  endtask
endmodule

/* smc_top_sva.sv */
`include "smc_consts.svh"

module smc_top_sva #(
  parameter int P_ADC_BITS = 14
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_sleep_cmd,
  input wire logic i_comm_activity,
  input wire logic i_sample_done,
  input wire logic i_scan_done,
  input wire logic i_adc_valid,
  input wire logic [P_ADC_BITS-1:0] i_adc_data,
  input smc_pkg::smc_mode_t o_mode,
  input smc_pkg::smc_kind_t o_scan_kind,
  input wire logic o_scan_start,
  input wire logic [`SMC_CELL_W-1:0] o_cell_sel,
  input wire logic o_factory_load,
  input wire logic o_result_filter_en,
  input wire logic o_fault_filter_en,
  input wire logic o_result_valid,
  input wire logic [P_ADC_BITS-1:0] o_result_data
);
  import smc_pkg::*;

  // one core clock domain
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_RAW_RESULT: assert property (
    i_adc_valid |=> o_result_valid && o_result_data == $past(i_adc_data))
    else $error("result not a raw copy of the converter word");
  AST_FILTER_FLAGS: assert property (
    $past(i_rst_n, 2) |-> o_fault_filter_en && !o_result_filter_en)
    else $error("filter enables wrong");
  AST_START_ACTIVE: assert property (
    o_scan_start && o_scan_kind != SMC_K_CONT |-> o_mode == SMC_ACTIVE)
    else $error("scan start without active mode");
  AST_VOLT_FROM_TOP: assert property (
    o_scan_start && o_scan_kind == SMC_K_VOLT |=> o_cell_sel == 4'hc)
    else $error("voltage scan not starting at cell twelve");
  AST_CELL_DOWN: assert property (
    o_mode == SMC_ACTIVE && o_scan_kind == SMC_K_VOLT && i_sample_done && !i_scan_done
      && o_cell_sel != 4'h0 |=> o_cell_sel == $past(o_cell_sel) - 4'h1)
    else $error("cell index did not step down");
  AST_DONE_STANDBY: assert property (
    o_mode == SMC_ACTIVE && i_scan_done |=> o_mode != SMC_ACTIVE)
    else $error("still active after scan done");
  AST_BUSY_IGNORE: assert property (
    o_mode == SMC_ACTIVE && !i_scan_done |=> !o_scan_start)
    else $error("scan started while busy");
  AST_SLEEP_CMD: assert property (
    o_mode == SMC_STANDBY && i_sleep_cmd && !i_comm_activity && i_enable
      && $past(i_enable) && $past(i_enable, 2) |=> o_mode == SMC_SLEEP)
    else $error("sleep command not taken");
  AST_WAKE: assert property (
    o_mode == SMC_SLEEP && i_comm_activity && i_enable |-> ##[1:3] o_mode == SMC_STANDBY)
    else $error("traffic did not wake the device");
  AST_SHUTDOWN: assert property (
    !i_enable [*4] |-> o_mode == SMC_SHUTDOWN)
    else $error("enable low did not shut down");
  AST_NO_RELOAD: assert property (
    o_mode != SMC_SHUTDOWN |-> !o_factory_load)
    else $error("factory load outside first power up");
endmodule

bind smc_top smc_top_sva #(.P_ADC_BITS(P_ADC_BITS)) u_sva (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(i_enable), .i_sleep_cmd(i_sleep_cmd),
  .i_comm_activity(i_comm_activity), .i_sample_done(i_sample_done),
  .i_scan_done(i_scan_done), .i_adc_valid(i_adc_valid), .i_adc_data(i_adc_data),
  .o_mode(o_mode), .o_scan_kind(o_scan_kind), .o_scan_start(o_scan_start),
  .o_cell_sel(o_cell_sel), .o_factory_load(o_factory_load),
  .o_result_filter_en(o_result_filter_en), .o_fault_filter_en(o_fault_filter_en),
  .o_result_valid(o_result_valid), .o_result_data(o_result_data));

/* testbench.sv */
`include "smc_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) report(a, e); end
`define PULSE(s) begin @(posedge i_clock); s <= 1'b1; @(posedge i_clock); s <= 1'b0; #1; end

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] size;
    logic [5:0] cmd;
    logic [5:0] suf;
    logic [5:0] roles;
    logic start;
    logic stream;
    smc_kind_t kind;
  } smc_row_t;

  // roles: spi, up, down, timing master, tags, forwarded
  smc_row_t rows [9] = '{
    '{4'h2, 4'h3, 6'h01, 6'h00, 6'h1b, 1'h1, 1'h0, SMC_K_VOLT},
    '{4'h3, 4'h3, 6'h02, 6'h00, 6'h0e, 1'h1, 1'h0, SMC_K_TEMP},
    '{4'h1, 4'h1, 6'h03, 6'h00, 6'h24, 1'h1, 1'h0, SMC_K_MIXED},
    '{4'h1, 4'h3, 6'h04, 6'h00, 6'h37, 1'h1, 1'h0, SMC_K_WIRES},
    '{4'h1, 4'h3, 6'h05, 6'h00, 6'h37, 1'h1, 1'h0, SMC_K_ALL},
    '{4'h1, 4'h3, 6'h08, 6'h2a, 6'h37, 1'h1, 1'h0, SMC_K_MEAS},
    '{4'h1, 4'h3, 6'h07, 6'h00, 6'h37, 1'h0, 1'h0, SMC_K_MEAS},
    '{4'h1, 4'h3, 6'h01, 6'h05, 6'h37, 1'h0, 1'h0, SMC_K_MEAS},
    '{4'h1, 4'h3, 6'h3f, 6'h00, 6'h37, 1'h0, 1'h1, SMC_K_MEAS}};

  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_link_clock, i_link_frame, i_link_data;
  logic [3:0] i_stack_pos = 4'h1;
  logic [3:0] i_stack_size = 4'h3;
  logic i_enable = 1'b1;
  logic i_sleep_cmd = 1'b0, i_wdog_timeout = 1'b0, i_comm_activity = 1'b0;
  logic i_scan_inhibit = 1'b0, i_scan_tick = 1'b0, i_sample_done = 1'b0;
  logic i_scan_done = 1'b0, i_adc_valid = 1'b0;
  logic [13:0] i_adc_data = 14'h0000;
  smc_mode_t o_mode;
  smc_kind_t o_scan_kind;
  smc_mode_t start_mode;
  logic o_scan_start, o_scan_cont, o_stream_start, o_fwd_cmd, o_timing_master;
  logic o_spi_en, o_port_up_en, o_port_down_en, o_tag_reply, o_config_err;
  logic o_fast_osc_en, o_bias_en, o_factory_load, o_result_filter_en;
  logic o_fault_filter_en, o_result_valid;
  logic [5:0] o_meas_elem;
  logic [3:0] o_cell_sel;
  logic [13:0] o_result_data;
  logic start_seen, stream_seen, fwd_seen;
  logic [3:0] dest = 4'hf;
  int num_errors = 0;
  int samples_checked = 0;
  int loads = 0;

  // core clock, 100 MHz
  always #5 i_clock = ~i_clock;

  smc_link_host host (.o_link_clock(i_link_clock), .o_link_frame(i_link_frame),
    .o_link_data(i_link_data));

  smc_top dut (.*);

  // factory load pulses over the whole run
  always @(posedge i_clock)
    if (o_factory_load === 1'b1) loads <= loads + 1;

  // pulses gathered from a frame's start until issue ends its wait
  always @(posedge i_clock)
  begin
    if (o_scan_start === 1'b1)
    begin
      start_seen <= 1'b1;
      start_mode <= o_mode;
    end
    if (o_stream_start === 1'b1) stream_seen <= 1'b1;
    if (o_fwd_cmd === 1'b1) fwd_seen <= 1'b1;
  end

  task automatic report(input logic [31:0] a, input logic [31:0] e);
    num_errors++;
    $display("Error at %0t: got %h expected %h", $time, a, e);
  endtask

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_mode(input smc_mode_t m);
    repeat (8)
      if (o_mode !== m)
      begin
        @(posedge i_clock);
        #1;
      end
    `CHK(o_mode, m)
  endtask

  // send one command read and note every pulse that follows it
  task automatic issue(input logic [5:0] c, input logic [5:0] s, input logic chain);
    start_seen = 1'b0;
    stream_seen = 1'b0;
    fwd_seen = 1'b0;
    if (chain)
      host.send({dest, c, s, 8'h00}, 24);
    else
      host.send({8'h00, c, s, 4'h0}, 16);
    repeat (12) @(posedge i_clock);
    #1;
  endtask

  // hang guard
  initial
  begin
    #500000;
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wait_mode(SMC_STANDBY);
    `CHK(o_config_err, 1'b0)
    for (int r = 0; r < 9; r++)
    begin
      @(posedge i_clock);
      i_stack_pos <= rows[r].pos;
      i_stack_size <= rows[r].size;
      repeat (6) @(posedge i_clock);
      #1;
      `CHK({o_spi_en, o_port_up_en, o_port_down_en, o_timing_master, o_tag_reply},
        rows[r].roles[5:1])
      issue(rows[r].cmd, rows[r].suf, rows[r].size > 4'h1);
      `CHK(fwd_seen, rows[r].roles[0])
      `CHK(start_seen, rows[r].start)
      `CHK(stream_seen, rows[r].stream)
      `CHK(o_scan_kind, rows[r].kind)
      if (rows[r].start)
      begin
        `CHK(start_mode, SMC_ACTIVE)
        `CHK(o_meas_elem, rows[r].suf)
        `PULSE(i_scan_done)
        `CHK(o_mode, SMC_STANDBY)
      end
    end
    // busy device ignores a scan but forwards it; cells step down to pack
    issue(6'h01, 6'h00, 1'b1);
    `CHK(o_cell_sel, 4'hc)
    issue(6'h02, 6'h00, 1'b1);
    `CHK(start_seen, 1'b0)
    `CHK(fwd_seen, 1'b1)
    `CHK(o_scan_kind, SMC_K_VOLT)
    for (int k = 11; k >= 0; k--)
    begin
      `PULSE(i_sample_done)
      `CHK(o_cell_sel, k[3:0])
    end
    `PULSE(i_scan_done)
    wait_mode(SMC_STANDBY);
    // continuous scanning, refused single scan, inhibit
    issue(6'h06, 6'h00, 1'b1);
    `CHK(o_scan_cont, 1'b1)
    `CHK(o_scan_kind, SMC_K_CONT)
    issue(6'h01, 6'h00, 1'b1);
    `CHK(start_seen, 1'b0)
    `PULSE(i_scan_tick)
    wait_mode(SMC_ACTIVE);
    `PULSE(i_scan_done)
    wait_mode(SMC_STANDBY);
    `PULSE(i_scan_inhibit)
    `CHK(o_scan_cont, 1'b0)
    // middle device: other position only forwards, own position starts and leads timing
    @(posedge i_clock);
    i_stack_pos <= 4'h2;
    dest = 4'h3;
    issue(6'h02, 6'h00, 1'b1);
    `CHK(start_seen, 1'b0)
    `CHK(fwd_seen, 1'b1)
    `CHK(o_timing_master, 1'b0)
    dest = 4'h2;
    issue(6'h02, 6'h00, 1'b1);
    `CHK(start_seen, 1'b1)
    `CHK(o_timing_master, 1'b1)
    `PULSE(i_scan_done)
    dest = 4'hf;
    // power modes
    `PULSE(i_sleep_cmd)
    wait_mode(SMC_SLEEP);
    `CHK(o_fast_osc_en, 1'b0)
    `CHK(o_bias_en, 1'b1)
    `PULSE(i_comm_activity)
    wait_mode(SMC_STANDBY);
    `PULSE(i_wdog_timeout)
    wait_mode(SMC_SLEEP);
    `PULSE(i_comm_activity)
    wait_mode(SMC_STANDBY);
    @(posedge i_clock);
    i_enable <= 1'b0;
    wait_mode(SMC_SHUTDOWN);
    `CHK(o_bias_en, 1'b0)
    @(posedge i_clock);
    i_enable <= 1'b1;
    wait_mode(SMC_STANDBY);
    `CHK(o_fast_osc_en, 1'b1)
    `CHK(loads, 1)
    // raw converter words
    @(posedge i_clock);
    i_adc_valid <= 1'b1;
    i_adc_data <= 14'h2abc;
    @(posedge i_clock);
    i_adc_valid <= 1'b0;
    #1;
    `CHK(o_result_valid, 1'b1)
    `CHK(o_result_data, 14'h2abc)
    `CHK(o_result_filter_en, 1'b0)
    `CHK(o_fault_filter_en, 1'b1)
    close_out();
  end
endmodule
